// ===== core/pll_guard_audio_clock_generators.sv
// pll recovery guard and three fractional audio rate generators
// behind a classic wishbone slave with 32-bit data and word registers
// assumes all pins and strobes are synchronous to clk_sys
//
// Function
// RULE_01: guard resets unstable pll while enabled
// RULE_02: relock keeps the pll settings unchanged
// RULE_03: control bit 0 enables guard, resets to one
// RULE_04: software keeps the guard enabled
// RULE_05: divider 1 denominator nine bits, reset six
// RULE_06: divider 1 numerator nine bits, reset one
// RULE_07: divider 2 denominator nine bits, reset nine
// RULE_08: divider 2 numerator nine bits, reset one
// RULE_09: divider 3 denominator sixteen bits, reset zero
// RULE_10: divider 3 numerator sixteen bits, reset zero
// RULE_11: bit 4 picks pll or external reference
// RULE_12: external rate is reference times numerator over 1024
// RULE_13: code 14 selects spdif, the reset default
// RULE_14: pll reference uses numerator over denominator
// RULE_15: external mode ignores the denominator
// RULE_16: external reference is a square wave
`timescale 1ns/100ps
`default_nettype none
module pll_guard_audio_clock_generators
  import clkgen_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [WB_ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic pll_lock,
  input wire logic [15:0] pll_setting,
  output logic pll_reset,
  output logic [15:0] pll_setting_held,
  input wire logic pll_ref_tick,
  input wire logic [MP_PIN_COUNT-1:0] multipurpose_pin,
  input wire logic spdif_ref_in,
  output logic audio_clk1_tick,
  output logic audio_clk2_tick,
  output logic audio_clk3_tick
);
  // software registers, stored at their field widths
  logic recovery_enable_q;                    // guard enable
  logic [DIV12_W-1:0] divider1_denominator_value;
  logic [DIV12_W-1:0] divider1_numerator_value;
  logic [DIV12_W-1:0] divider2_denominator_value;
  logic [DIV12_W-1:0] divider2_numerator_value;
  logic [DIV3_W-1:0] divider3_denominator_value;
  logic [DIV3_W-1:0] divider3_numerator_value;
  logic divider3_external_ref_select;        // 1 external, 0 pll
  logic [REF_CODE_W-1:0] divider3_ref_input_code;

  // bus slave state
  logic ack_q;          // acknowledge, one cycle per request
  logic [31:0] dat_q;   // read data captured with the acknowledge
  logic [15:0] idx;     // word index of the request
  logic req;            // request seen, not yet acknowledged
  logic wr_en;          // write takes effect at this edge
  logic [15:0] rd_word; // current value of the addressed register
  logic [15:0] wr_word; // addressed register with byte lanes merged

  // guard status
  logic guard_recovering;
  logic guard_locked;
  logic [7:0] guard_count;

  // external reference path
  logic ref_level;  // level on the selected reference input
  logic ref_prev_q; // level one cycle earlier
  logic ext_rise;   // rising edge of the external reference

  // the three generators
  divider_if #(.W(DIV12_W)) d1_if ();
  divider_if #(.W(DIV12_W)) d2_if ();
  divider_if #(.W(DIV3_W)) d3_if ();

  // merge the enabled low byte lanes into the old value
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [15:0] nw,
    input logic [1:0] be
  );
    merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  assign idx = wb_adr[WB_ADR_W-1:2];
  assign req = wb_cyc && wb_stb && !ack_q;
  // the master samples ack at the edge where the write lands
  assign wr_en = wb_cyc && wb_stb && wb_we && ack_q;
  assign wr_word = merge16(rd_word, wb_dat_w[15:0], wb_sel[1:0]);

  // read mux; reserved bits and unmapped words read as zero
  always_comb begin
    case (idx)
      IDX_PLL_RECOVERY_CONTROL: begin
        rd_word = {15'h0000, recovery_enable_q};
      end
      IDX_DIV1_DEN: begin
        rd_word = {7'h00, divider1_denominator_value};
      end
      IDX_DIV1_NUM: begin
        rd_word = {7'h00, divider1_numerator_value};
      end
      IDX_DIV2_DEN: begin
        rd_word = {7'h00, divider2_denominator_value};
      end
      IDX_DIV2_NUM: begin
        rd_word = {7'h00, divider2_numerator_value};
      end
      IDX_DIV3_DEN: begin
        rd_word = divider3_denominator_value;
      end
      IDX_DIV3_NUM: begin
        rd_word = divider3_numerator_value;
      end
      IDX_DIV3_REF_SELECT: begin
        rd_word = {11'h000, divider3_external_ref_select,
                   divider3_ref_input_code};
      end
      IDX_RECOVERY_STATUS: begin
        rd_word = {guard_count, 6'h00, guard_recovering, guard_locked};
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  // acknowledge and read data, one cycle after the request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      if (req) begin
        dat_q <= {16'h0000, rd_word};
      end
    end
  end

  // guard control register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      recovery_enable_q <= RST_RECOVERY_ENABLE; // RULE_03
    end else if (wr_en && idx == IDX_PLL_RECOVERY_CONTROL) begin
      recovery_enable_q <= wr_word[0]; // RULE_03
    end
  end

  // dividers 1 and 2: nine-bit fields, upper bits dropped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      divider1_denominator_value <= RST_DIV1_DEN; // RULE_05
      divider1_numerator_value <= RST_DIV1_NUM; // RULE_06
      divider2_denominator_value <= RST_DIV2_DEN; // RULE_07
      divider2_numerator_value <= RST_DIV2_NUM; // RULE_08
    end else if (wr_en) begin
      if (idx == IDX_DIV1_DEN) begin
        divider1_denominator_value <= wr_word[8:0]; // RULE_05
      end
      if (idx == IDX_DIV1_NUM) begin
        divider1_numerator_value <= wr_word[8:0]; // RULE_06
      end
      if (idx == IDX_DIV2_DEN) begin
        divider2_denominator_value <= wr_word[8:0]; // RULE_07
      end
      if (idx == IDX_DIV2_NUM) begin
        divider2_numerator_value <= wr_word[8:0]; // RULE_08
      end
    end
  end

  // divider 3: full-width ratio and reference select
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      divider3_denominator_value <= RST_DIV3_DEN; // RULE_09
      divider3_numerator_value <= RST_DIV3_NUM; // RULE_10
      divider3_external_ref_select <= RST_DIV3_REF_SELECT[REF_SEL_BIT];
      divider3_ref_input_code <= RST_DIV3_REF_SELECT[3:0]; // RULE_13
    end else if (wr_en) begin
      if (idx == IDX_DIV3_DEN) begin
        divider3_denominator_value <= wr_word; // RULE_09
      end
      if (idx == IDX_DIV3_NUM) begin
        divider3_numerator_value <= wr_word; // RULE_10
      end
      if (idx == IDX_DIV3_REF_SELECT) begin
        divider3_external_ref_select <= wr_word[REF_SEL_BIT]; // RULE_11
        divider3_ref_input_code <= wr_word[3:0];
      end
    end
  end

  // pick the reference input: pins by code, spdif on its code, else low
  always_comb begin
    if (divider3_ref_input_code == CODE_SPDIF) begin
      ref_level = spdif_ref_in; // RULE_13
    end else if (32'(divider3_ref_input_code) < MP_PIN_COUNT) begin
      ref_level = multipurpose_pin[divider3_ref_input_code];
    end else begin
      ref_level = 1'b0;
    end
  end

  // edge detect: one strobe per reference period of a square wave
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_level;
    end
  end
  assign ext_rise = ref_level && !ref_prev_q;

  // generator ratios; divider 3 external mode divides by a fixed 1024
  assign d1_if.numerator = divider1_numerator_value;
  assign d1_if.denominator = divider1_denominator_value;
  assign d1_if.ref_tick = pll_ref_tick;
  assign d2_if.numerator = divider2_numerator_value;
  assign d2_if.denominator = divider2_denominator_value;
  assign d2_if.ref_tick = pll_ref_tick;
  assign d3_if.numerator = divider3_numerator_value; // RULE_12
  assign d3_if.denominator = divider3_external_ref_select ?
    EXT_SCALE : divider3_denominator_value; // RULE_14 RULE_15
  assign d3_if.ref_tick = divider3_external_ref_select ?
    ext_rise : pll_ref_tick; // RULE_11

  frac_divider #(.W(DIV12_W)) u_div1 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .dv(d1_if.gen)
  );
  frac_divider #(.W(DIV12_W)) u_div2 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .dv(d2_if.gen)
  );
  frac_divider #(.W(DIV3_W)) u_div3 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .dv(d3_if.gen)
  );

  // recovery guard steered by the control register
  pll_guard u_guard (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .enable(recovery_enable_q), // RULE_01
    .pll_lock(pll_lock),
    .pll_setting(pll_setting),
    .pll_reset(pll_reset),
    .pll_setting_held(pll_setting_held),
    .recovering(guard_recovering),
    .locked(guard_locked),
    .recovery_count(guard_count)
  );

  assign wb_ack = ack_q;
  assign wb_dat_r = dat_q;
  assign audio_clk1_tick = d1_if.out_tick;
  assign audio_clk2_tick = d2_if.out_tick;
  assign audio_clk3_tick = d3_if.out_tick;

  property p_ctrl_reset;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> recovery_enable_q;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) // RULE_03
    else $error("guard not enabled after reset");

  property p_ctrl_write;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_en && idx == IDX_PLL_RECOVERY_CONTROL && wb_sel[0]) |=>
      (wb_dat_r[0] == recovery_enable_q || !wb_ack) &&
      recovery_enable_q == $past(wb_dat_w[0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) // RULE_03
    else $error("control bit not written");

  property p_div1_den;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> divider1_denominator_value == 9'h006;
  endproperty
  a_div1_den: assert property (p_div1_den) // RULE_05
    else $error("divider 1 denominator reset wrong");

  property p_div1_num;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_en && idx == IDX_DIV1_NUM && wb_sel[1:0] == 2'h3) |=>
      divider1_numerator_value == $past(wb_dat_w[8:0]);
  endproperty
  a_div1_num: assert property (p_div1_num) // RULE_06
    else $error("divider 1 numerator not written");

  property p_div2_den;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> divider2_denominator_value == 9'h009;
  endproperty
  a_div2_den: assert property (p_div2_den) // RULE_07
    else $error("divider 2 denominator reset wrong");

  property p_div2_num;
    @(posedge clk_sys) disable iff (!rst_n)
    (wb_ack && !wb_we && idx == IDX_DIV2_NUM) |->
      wb_dat_r[15:9] == 7'h00;
  endproperty
  a_div2_num: assert property (p_div2_num) // RULE_08
    else $error("divider 2 numerator reserved bits set");

  property p_div3_den;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_en && idx == IDX_DIV3_DEN && wb_sel[1:0] == 2'h3) |=>
      divider3_denominator_value == $past(wb_dat_w[15:0]);
  endproperty
  a_div3_den: assert property (p_div3_den) // RULE_09
    else $error("divider 3 denominator not written");

  property p_div3_num;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> divider3_numerator_value == 16'h0000;
  endproperty
  a_div3_num: assert property (p_div3_num) // RULE_10
    else $error("divider 3 numerator reset wrong");

  property p_pll_ref;
    @(posedge clk_sys) disable iff (!rst_n)
    !divider3_external_ref_select |->
      (d3_if.ref_tick == pll_ref_tick &&
       d3_if.denominator == divider3_denominator_value);
  endproperty
  a_pll_ref: assert property (p_pll_ref) // RULE_11 RULE_14
    else $error("divider 3 not on pll reference");

  property p_ext_scale;
    @(posedge clk_sys) disable iff (!rst_n)
    divider3_external_ref_select |-> d3_if.denominator == 16'h0400;
  endproperty
  a_ext_scale: assert property (p_ext_scale) // RULE_12 RULE_15
    else $error("external mode not scaled by 1024");

  property p_spdif;
    @(posedge clk_sys) disable iff (!rst_n)
    (divider3_external_ref_select && divider3_ref_input_code == 4'hE &&
     spdif_ref_in && !$past(spdif_ref_in) &&
     $stable(divider3_ref_input_code)) |-> d3_if.ref_tick;
  endproperty
  a_spdif: assert property (p_spdif) // RULE_13
    else $error("spdif edge not passed to divider 3");

  c_write: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wr_en && idx == IDX_DIV3_REF_SELECT);
  c_ext_tick: cover property (@(posedge clk_sys) disable iff (!rst_n)
    divider3_external_ref_select && audio_clk3_tick);
  c_guard_reset: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(pll_reset));
endmodule
`default_nettype wire

// ===== pkg/clkgen_pkg.sv
// constants, reset values and types shared by the clock control block
// assumes a 40 MHz system clock and word-indexed wishbone registers
`default_nettype none
package clkgen_pkg;
  // system clock period
  localparam int CLK_PERIOD_NS = 25;
  // longest wait for lock before the guard declares the pll unstable
  localparam int LOCK_TIMEOUT_NS = 100000;
  localparam int LOCK_WAIT_CYCLES = LOCK_TIMEOUT_NS / CLK_PERIOD_NS;
  // least width of the pll reset pulse
  localparam int PLL_RESET_NS = 1000;
  localparam int PLL_RESET_CYCLES =
    (PLL_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // guard counter and its terminal counts
  localparam int GUARD_CNT_W = 12;
  localparam logic [11:0] LOCK_WAIT_LAST = 12'(LOCK_WAIT_CYCLES - 1);
  localparam logic [11:0] RESET_LAST = 12'(PLL_RESET_CYCLES - 1);
  // register word indices; byte address is four times the index
  localparam logic [15:0] IDX_PLL_RECOVERY_CONTROL = 16'hF006;
  localparam logic [15:0] IDX_DIV1_DEN = 16'hF020;
  localparam logic [15:0] IDX_DIV1_NUM = 16'hF021;
  localparam logic [15:0] IDX_DIV2_DEN = 16'hF022;
  localparam logic [15:0] IDX_DIV2_NUM = 16'hF023;
  localparam logic [15:0] IDX_DIV3_DEN = 16'hF024;
  localparam logic [15:0] IDX_DIV3_NUM = 16'hF025;
  localparam logic [15:0] IDX_DIV3_REF_SELECT = 16'hF026;
  localparam logic [15:0] IDX_RECOVERY_STATUS = 16'hF030;
  // bus geometry
  localparam int WB_ADR_W = 18;
  // field widths
  localparam int DIV12_W = 9;
  localparam int DIV3_W = 16;
  localparam int REF_CODE_W = 4;
  localparam int REF_SEL_BIT = 4;
  localparam int MP_PIN_COUNT = 14;
  localparam int STAT_COUNT_LSB = 8;
  // values after reset
  localparam logic RST_RECOVERY_ENABLE = 1'b1;
  localparam logic [8:0] RST_DIV1_DEN = 9'h006;
  localparam logic [8:0] RST_DIV1_NUM = 9'h001;
  localparam logic [8:0] RST_DIV2_DEN = 9'h009;
  localparam logic [8:0] RST_DIV2_NUM = 9'h001;
  localparam logic [15:0] RST_DIV3_DEN = 16'h0000;
  localparam logic [15:0] RST_DIV3_NUM = 16'h0000;
  localparam logic [4:0] RST_DIV3_REF_SELECT = 5'h0E;
  // reference codes and fixed scaling of the external reference
  localparam logic [3:0] CODE_SPDIF = 4'hE;
  localparam logic [15:0] EXT_SCALE = 16'h0400;
  // pll guard sequencer
  typedef enum logic [1:0] {
    GUARD_WAIT,
    GUARD_LOCKED,
    GUARD_RESET
  } guard_state_type;
endpackage
`default_nettype wire

// ===== pkg/divider_if.sv
// ratio, reference strobe and output strobe of one fractional divider
// assumes one control end and one generator end on the same clock
`timescale 1ns/100ps
`default_nettype none
interface divider_if #(parameter int W = 9);
  logic [W-1:0] numerator;   // multiply factor
  logic [W-1:0] denominator; // divide factor, zero stops the output
  logic ref_tick;            // one pulse per reference period
  logic out_tick;            // one pulse per output period
  modport ctrl (output numerator, output denominator, output ref_tick,
                input out_tick);
  modport gen (input numerator, input denominator, input ref_tick,
               output out_tick);
endinterface
`default_nettype wire

// ===== core/frac_divider.sv
// fractional rate generator: out rate = ref rate * numerator / denominator
// assumes reference strobes far sparser than the system clock
`timescale 1ns/100ps
`default_nettype none
module frac_divider #(
  parameter int W = 9
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  divider_if.gen dv
);
  localparam int AW = W + 2;
  logic [AW-1:0] acc_q;  // pending output periods times denominator
  logic tick_q;          // registered output strobe
  logic [AW-1:0] num_x;  // widened numerator
  logic [AW-1:0] den_x;  // widened denominator
  logic drain;           // one output period is due

  assign num_x = AW'(dv.numerator);
  assign den_x = AW'(dv.denominator);
  assign drain = (den_x != '0) && (acc_q >= den_x);

  // add numerator per reference strobe, take one denominator per tick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      tick_q <= 1'b0;
    end else if (den_x == '0) begin
      // zero denominator holds the generator still
      acc_q <= '0;
      tick_q <= 1'b0;
    end else begin
      acc_q <= acc_q + (dv.ref_tick ? num_x : '0) - (drain ? den_x : '0);
      tick_q <= drain;
    end
  end

  assign dv.out_tick = tick_q;

  // a zero denominator silences the output from the next edge
  property p_stopped;
    @(posedge clk_sys) disable iff (!rst_n)
    (den_x == '0) |=> !tick_q;
  endproperty
  a_stopped: assert property (p_stopped) // RULE_14
    else $error("tick with zero den");
endmodule
`default_nettype wire

// ===== core/pll_guard.sv
// pll recovery guard: watches lock, pulses pll reset, freezes settings
// assumes pll_lock is synchronous to clk_sys
`timescale 1ns/100ps
`default_nettype none
module pll_guard
  import clkgen_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic pll_lock,
  input wire logic [15:0] pll_setting,
  output logic pll_reset,
  output logic [15:0] pll_setting_held,
  output logic recovering,
  output logic locked,
  output logic [7:0] recovery_count
);
  guard_state_type state_q;     // sequencer state
  logic [GUARD_CNT_W-1:0] cnt_q; // timeout and pulse counter
  logic reset_q;                 // pll reset pulse
  logic recover_q;               // recovery in progress
  logic lock_q;                  // registered lock flag
  logic [15:0] cfg_q;            // settings handed to the pll
  logic [7:0] count_q;           // saturating recovery count
  logic fault;                   // unstable pll seen while enabled

  assign fault = enable && !pll_lock &&
    ((state_q == GUARD_LOCKED) ||
     ((state_q == GUARD_WAIT) && (cnt_q == LOCK_WAIT_LAST)));

  // sequencer: monitor, pulse reset on a fault, then wait for relock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= GUARD_WAIT;
      cnt_q <= '0;
      reset_q <= 1'b0;
    end else begin
      unique case (state_q)
        GUARD_WAIT: begin
          if (pll_lock) begin
            state_q <= GUARD_LOCKED;
            cnt_q <= '0;
          end else if (fault) begin
            state_q <= GUARD_RESET; // RULE_01
            cnt_q <= '0;
            reset_q <= 1'b1;
          end else if (cnt_q == LOCK_WAIT_LAST) begin
            cnt_q <= '0; // disabled: keep waiting
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        GUARD_LOCKED: begin
          if (fault) begin
            state_q <= GUARD_RESET; // RULE_01
            reset_q <= 1'b1;
          end else if (!pll_lock) begin
            state_q <= GUARD_WAIT;
          end
          cnt_q <= '0;
        end
        GUARD_RESET: begin
          if (cnt_q == RESET_LAST) begin
            state_q <= GUARD_WAIT; // relock attempt starts
            reset_q <= 1'b0;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // recovery flag: set at the fault, cleared at relock; count rises by one per fault, holding at 255
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      recover_q <= 1'b0;
      count_q <= 8'h00;
    end else if (fault && state_q != GUARD_RESET) begin
      recover_q <= 1'b1;
      if (count_q != 8'hFF) begin
        count_q <= count_q + 8'h01;
      end
    end else if (state_q == GUARD_WAIT && pll_lock) begin
      recover_q <= 1'b0;
    end
  end

  // settings follow software, frozen from the fault edge until relock
  // so the pll relocks with what it held before its reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= 16'h0000;
      lock_q <= 1'b0;
    end else begin
      lock_q <= pll_lock;
      if (!recover_q && !fault) begin
        cfg_q <= pll_setting; // RULE_02
      end
    end
  end

  assign pll_reset = reset_q;
  assign pll_setting_held = cfg_q;
  assign recovering = recover_q;
  assign locked = lock_q;
  assign recovery_count = count_q;

  property p_lock_loss;
    @(posedge clk_sys) disable iff (!rst_n)
    (enable && state_q == GUARD_LOCKED && !pll_lock) |=>
      (reset_q && recover_q);
  endproperty
  a_lock_loss: assert property (p_lock_loss) // RULE_01
    else $error("no pll reset after lock loss");

  property p_timeout;
    @(posedge clk_sys) disable iff (!rst_n)
    (enable && state_q == GUARD_WAIT && cnt_q == LOCK_WAIT_LAST &&
     !pll_lock) |=> reset_q;
  endproperty
  a_timeout: assert property (p_timeout) // RULE_01
    else $error("no pll reset after lock timeout");

  property p_frozen;
    @(posedge clk_sys) disable iff (!rst_n)
    (fault || recover_q) |=> $stable(cfg_q);
  endproperty
  a_frozen: assert property (p_frozen) // RULE_02
    else $error("pll settings changed during recovery");

  property p_relock;
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(reset_q) |-> (state_q == GUARD_WAIT && recover_q);
  endproperty
  a_relock: assert property (p_relock) // RULE_02
    else $error("no relock attempt after pll reset");

  c_recovery: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(recover_q));
endmodule
`default_nettype wire

// ===== testbench/tb_pll_guard_audio_clock_generators.sv
// self-checking bench for the pll guard and audio rate generators
// assumes word registers at byte address four times the index
`timescale 1ns/100ps
`default_nettype none
module tb_pll_guard_audio_clock_generators;
  import clkgen_pkg::*;
  logic clk_sys = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, lk = 1;
  logic rt = 0, sp = 0;
  logic [17:0] adr = '0;
  logic [31:0] dat = '0, rdat, q;
  logic [15:0] ps = '0, held;
  logic ack, prst, t1, t2, t3;
  int n_errors = 0, num_checks = 0, n1 = 0, n2 = 0, n3 = 0;
  // register table: index, reset value, writable mask
  logic [15:0] ix[8] = '{16'hF006, 16'hF020, 16'hF021, 16'hF022,
    16'hF023, 16'hF024, 16'hF025, 16'hF026};
  logic [15:0] rv[8] = '{16'h0001, 16'h0006, 16'h0001, 16'h0009,
    16'h0001, 16'h0000, 16'h0000, 16'h000E};
  logic [15:0] mk[8] = '{16'h0001, 16'h01FF, 16'h01FF, 16'h01FF,
    16'h01FF, 16'hFFFF, 16'hFFFF, 16'h001F};
  // reference select words: spdif, then multipurpose pin 5
  logic [15:0] cd[2] = '{16'h001E, 16'h0015};
  pll_guard_audio_clock_generators uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(4'hF),
    .wb_dat_w(dat), .wb_dat_r(rdat), .wb_ack(ack), .pll_lock(lk),
    .pll_setting(ps), .pll_reset(prst), .pll_setting_held(held),
    .pll_ref_tick(rt), .multipurpose_pin({8'h00, sp, 5'h00}),
    .spdif_ref_in(sp),
    .audio_clk1_tick(t1), .audio_clk2_tick(t2), .audio_clk3_tick(t3));
  // clock and tick counters
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    n1 += (t1 === 1'b1);
    n2 += (t2 === 1'b1);
    n3 += (t3 === 1'b1);
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [15:0] i,
                     input logic [15:0] d);
    int k;
    @(posedge clk_sys);
    cyc <= 1; stb <= 1; we <= w; adr <= {i, 2'b00}; dat <= {16'h0000, d};
    k = 0;
    do begin @(posedge clk_sys); k++; end while (ack !== 1'b1 && k < 20);
    q = rdat;
    if (k >= 20) begin
      chk(0, 1);
      tally_and_finish();
    end
    cyc <= 0; stb <= 0;
  endtask
  task automatic regs_scn;
    for (int i = 0; i < 8; i++) begin
      bus(0, ix[i], 0); chk(q, {16'h0, rv[i]});
      bus(1, ix[i], 16'hFFFF); bus(0, ix[i], 0);
      chk(q, {16'h0, mk[i]});
      bus(1, ix[i], rv[i]);
    end
    bus(1, 16'hF010, 16'hFFFF); bus(0, 16'hF010, 0); chk(q, 0);
  endtask
  task automatic pll_gen_scn;
    bus(1, 16'hF024, 16'h0004); bus(1, 16'hF025, 16'h0001);
    n1 = 0; n2 = 0; n3 = 0;
    repeat (12) begin
      @(posedge clk_sys); rt <= 1; @(posedge clk_sys); rt <= 0;
      repeat (6) @(posedge clk_sys);
    end
    chk(n1, 2); chk(n2, 1);
    chk(n3, 3);
  endtask
  task automatic ext_gen_scn;
    bus(1, 16'hF024, 16'h0001); bus(1, 16'hF025, 16'h0200);
    foreach (cd[j]) begin
      bus(1, 16'hF026, cd[j]);
      n3 = 0;
      // square wave, eight cycles high and eight low
      repeat (4) begin
        sp <= 1;
        repeat (8) @(posedge clk_sys);
        sp <= 0;
        repeat (8) @(posedge clk_sys);
      end
      chk(n3, 2);
    end
    bus(1, 16'hF026, 16'h000E);
  endtask
  task automatic guard_scn;
    int k;
    @(posedge clk_sys); ps <= 16'h1234; repeat (3) @(posedge clk_sys);
    chk(held, 16'h1234);
    lk <= 0; ps <= 16'h5678; k = 0;
    do begin @(posedge clk_sys); k++; end while (prst !== 1'b1 && k < 4);
    chk(k < 4, 1);
    if (k >= 4) begin
      tally_and_finish();
    end
    repeat (10) @(posedge clk_sys);
    chk(held, 16'h1234);
    repeat (40) @(posedge clk_sys); lk <= 1; repeat (5) @(posedge clk_sys);
    chk({prst, held}, {1'b0, 16'h5678});
    bus(1, 16'hF006, 16'h0000); @(posedge clk_sys); lk <= 0; k = 0;
    repeat (20) begin @(posedge clk_sys); k += (prst !== 1'b0); end
    chk(k, 0);
    // re-enabled while still unlocked: the lock timeout must fire
    bus(1, 16'hF006, 16'h0001);
    k = 0;
    do begin @(posedge clk_sys); k++; end while (prst !== 1'b1 && k < 4100);
    chk(k < 4100, 1);
    lk <= 1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1;
    regs_scn();
    pll_gen_scn();
    ext_gen_scn();
    guard_scn();
    tally_and_finish();
  end
endmodule
`default_nettype wire
